// file: host_parallel_port_regsel.sv
// Register selection, control register and flags of the parallel host port
`timescale 1ns/1ps
// Function
// [RQ1] Host select bus decoded per mapping mode
// [RQ2] All host-accessible; error source read-only
// [RQ3] Map select picks legacy or extended mapping
// [RQ4] Wide select: 8-bit or 16-bit host data
// [RQ5] Host avoids wide set with map clear
// [RQ6] Legacy codes map bytes; high codes interrupt
// [RQ7] 8-bit extended mapping adds extra registers
// [RQ8] 16-bit mode maps whole registers only
// [RQ9] Code 1010 reaches control high in 16-bit
// [RQ10] Control register 16 bits, host writable
// [RQ11] Interrupt flag enable gates interrupt flag
// [RQ12] Control bit 3 enables port DMA
// [RQ13] DMA width: 16 or 32 bits
// [RQ14] Flag edge selects leading/trailing read update
// [RQ15] Run bit; rising edge restarts processor
// [RQ16] Autoincrement pointer after each DMA
// [RQ17] Reset clears control except run bit
// [RQ18] Host sets map select before control high
module host_parallel_port_regsel (
  input wire logic mclk,
  input wire logic rst,
  input wire host_port_pkg::host_req_s host,
  output logic [15:0] host_rdata_q,
  output logic host_rdata_oe_q,
  output logic data_full_flag_q,
  output logic host_interrupt_flag_q,
  input wire logic core_iw_write,
  input wire logic [15:0] core_iw_wdata,
  output logic [15:0] iw_to_core_q,
  output logic iw_to_core_stb_q,
  input wire logic [7:0] err_set,
  output logic core_err_halt_q,
  output logic core_run_q,
  output logic core_restart_q,
  output host_port_pkg::dma_req_s dma_q,
  input wire logic dma_ack,
  input wire logic [31:0] dma_rdata
);
  import host_port_pkg::*;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Map select first: wide without map falls back to legacy decode
  function automatic tgt_e decode(input logic [3:0] s, input logic map,
                                  input logic wide);
    tgt_e t;
    t = T_NONE;
    if (s == SEL_ESR) t = T_ESR;
    if (!map) begin // [RQ3] [RQ6]
      if (s == SEL_PTR_LO) t = T_PTR_LO;
      else if (s == SEL_PTR_HI) t = T_PTR_HI;
      else if (s == SEL_DAT_LO) t = T_DAT_LO;
      else if (s == SEL_DAT_HI) t = T_DAT_HI;
      else if (s == SEL_MSK_LO) t = T_MSK_LO;
      else if (s == SEL_MSK_HI) t = T_MSK_HI;
      else if (s == SEL_CTL_LO) t = T_CTL_LO;
      else if (s >= SEL_IW_LO) t = T_IW_HI;
    end else if (!wide) begin // [RQ7] [RQ18]
      if (s == SEL_PTR_LO) t = T_PTR_LO;
      else if (s == SEL_PTR_HI) t = T_PTR_HI;
      else if (s == SEL_DAT_LO) t = T_DAT_LO;
      else if (s == SEL_DAT_HI) t = T_DAT_HI;
      else if (s == SEL_MSK_LO) t = T_MSK_LO;
      else if (s == SEL_MSK_HI) t = T_MSK_HI;
      else if (s == SEL_CTL_LO) t = T_CTL_LO;
      else if (s == SEL_IW_LO) t = T_IW_LO;
      else if (s == SEL_IW_HI) t = T_IW_HI;
      else if (s == SEL_CTL_HI) t = T_CTL_HI;
      else if (s == SEL_EXT) t = T_EXT;
      else if (s == SEL_D2_LO) t = T_D2_LO;
      else if (s == SEL_D2_HI) t = T_D2_HI;
    end else begin // [RQ8]
      if (s == SEL_PTR_LO) t = T_PTR_W;
      else if (s == SEL_DAT_LO) t = T_DAT_W;
      else if (s == SEL_MSK_LO) t = T_MSK_W;
      else if (s == SEL_CTL_LO) t = T_CTL_W;
      else if (s == SEL_IW_LO) t = T_IW_W;
      else if (s == SEL_CTL_HI) t = T_CTL_HI; // [RQ9]
      else if (s == SEL_EXT) t = T_EXT;
      else if (s == SEL_D2_LO) t = T_D2_W;
    end
    return t;
  endfunction : decode

  // Byte lanes {hi, lo} that an access to a 16-bit register touches
  function automatic logic [1:0] lanes(input tgt_e t, input tgt_e lo,
                                       input tgt_e hi, input tgt_e w);
    return {(t == hi) || (t == w), (t == lo) || (t == w)};
  endfunction : lanes

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] d,
                                        input logic [1:0] ln);
    return {ln[1] ? d[15:8] : old[15:8], ln[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  // ==========================================================================
  // Registers and access strobes
  // ==========================================================================
  logic [15:0] ctl_q, ptr_q, dat_q, dat2_q, msk_q, iw_q;
  logic [7:0] ext_q, esr_q;
  logic wr_q, rd_q, run_prev_q, dir_wr_q;
  tgt_e rd_tgt_q;
  dma_st_e dma_st_q;
  tgt_e cur_tgt, eff_tgt;
  logic wr_take, rd_lead, rd_trail, rd_eff;
  logic [15:0] wd16;
  logic last_wr, last_rd, iw_rd;

  assign cur_tgt = decode(host.sel, ctl_q[CTL_MAP], ctl_q[CTL_WIDE]); // [RQ1]
  assign wr_take = host.wr && !wr_q;
  assign rd_lead = host.rd && !rd_q;
  assign rd_trail = !host.rd && rd_q;
  // Trailing-edge mode acts on the target latched when the read began
  assign rd_eff = ctl_q[CTL_FLG] ? rd_trail : rd_lead; // [RQ14]
  assign eff_tgt = ctl_q[CTL_FLG] ? rd_tgt_q : cur_tgt; // [RQ14]
  // Byte accesses carry data in the low byte of the host bus
  assign wd16 = ctl_q[CTL_MAP] && ctl_q[CTL_WIDE] ? host.wdata
                : {host.wdata[7:0], host.wdata[7:0]};
  // The last data unit of a DMA word depends on the DMA width
  assign last_wr = wr_take && (ctl_q[CTL_DMA_W] // [RQ13]
                   ? (cur_tgt == T_D2_HI || cur_tgt == T_D2_W)
                   : (cur_tgt == T_DAT_HI || cur_tgt == T_DAT_W));
  assign last_rd = rd_eff && (ctl_q[CTL_DMA_W]
                   ? (eff_tgt == T_D2_HI || eff_tgt == T_D2_W)
                   : (eff_tgt == T_DAT_HI || eff_tgt == T_DAT_W));
  assign iw_rd = rd_eff && (eff_tgt == T_IW_HI || eff_tgt == T_IW_W);

  // Edge history of the host strobes
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rd_tgt_q <= T_NONE;
    end else begin
      wr_q <= host.wr;
      rd_q <= host.rd;
      if (rd_lead) rd_tgt_q <= cur_tgt;
    end
  end

  // Control register; status bits 5 and 6 are read-only mirrors
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctl_q <= CTL_RESET; // [RQ17]
    end else if (wr_take) begin // [RQ10]
      ctl_q <= merge(ctl_q, wd16, lanes(cur_tgt, T_CTL_LO, T_CTL_HI, T_CTL_W))
               & CTL_WMASK;
    end
  end

  // Run control; a 0-to-1 edge on the run bit restarts the core
  always_ff @(posedge mclk) begin
    if (rst) begin
      run_prev_q <= 1'b1;
      core_run_q <= 1'b1;
      core_restart_q <= 1'b0;
    end else begin
      run_prev_q <= ctl_q[CTL_RUN];
      core_run_q <= ctl_q[CTL_RUN]; // [RQ15]
      core_restart_q <= ctl_q[CTL_RUN] && !run_prev_q; // [RQ15]
    end
  end

  // Error mask and error source; a new error beats the clear on read
  always_ff @(posedge mclk) begin
    if (rst) begin
      msk_q <= EMR_RESET;
      esr_q <= 8'h00;
      core_err_halt_q <= 1'b0;
    end else begin
      if (wr_take) begin
        msk_q <= merge(msk_q, wd16, lanes(cur_tgt, T_MSK_LO, T_MSK_HI, T_MSK_W));
      end
      // Host writes to the error source are dropped
      esr_q <= ((rd_trail && rd_tgt_q == T_ESR) ? 8'h00 : esr_q) // [RQ2]
               | (err_set & ESR_VALID)
               | ((wr_take && (cur_tgt == T_IW_HI || cur_tgt == T_IW_W))
                  ? 8'h04 : 8'h00);
      core_err_halt_q <= |(esr_q & ~msk_q[15:8]);
    end
  end

  // Interrupt word and its flag; the core write sets, host read clears
  always_ff @(posedge mclk) begin
    if (rst) begin
      iw_q <= 16'h0000;
      iw_to_core_q <= 16'h0000;
      iw_to_core_stb_q <= 1'b0;
      host_interrupt_flag_q <= 1'b0;
    end else begin
      iw_to_core_stb_q <= 1'b0;
      if (core_iw_write) begin
        iw_q <= core_iw_wdata;
      end else if (wr_take) begin
        iw_q <= merge(iw_q, wd16, lanes(cur_tgt, T_IW_LO, T_IW_HI, T_IW_W));
        if (cur_tgt == T_IW_HI || cur_tgt == T_IW_W) begin
          iw_to_core_q <= merge(iw_q, wd16, lanes(cur_tgt, T_IW_LO, T_IW_HI,
                                                  T_IW_W));
          iw_to_core_stb_q <= 1'b1;
        end
      end
      if (ctl_q[CTL_IFE]) begin // [RQ11]
        if (core_iw_write) host_interrupt_flag_q <= 1'b1;
        else if (iw_rd) host_interrupt_flag_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Pointer, data registers and the DMA engine
  // ==========================================================================
  // Host writes win over an autoincrement in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      ptr_q <= 16'h0000;
      ext_q <= 8'h00;
    end else begin
      if (dma_ack && dma_st_q != D_IDLE && ctl_q[CTL_AUTO]) begin // [RQ16]
        {ext_q, ptr_q} <= 24'({ext_q, ptr_q}
                          + (ctl_q[CTL_DMA_W] ? INC_32 : INC_16));
      end
      if (wr_take) begin
        ptr_q <= merge(ptr_q, wd16, lanes(cur_tgt, T_PTR_LO, T_PTR_HI, T_PTR_W));
        if (cur_tgt == T_EXT) ext_q <= wd16[7:0];
      end
    end
  end

  // Data registers: host writes, or DMA fill in the read direction
  always_ff @(posedge mclk) begin
    if (rst) begin
      dat_q <= 16'h0000;
      dat2_q <= 16'h0000;
    end else if (dma_ack && dma_st_q == D_READ) begin
      dat_q <= dma_rdata[15:0];
      if (ctl_q[CTL_DMA_W]) dat2_q <= dma_rdata[31:16]; // [RQ13]
    end else if (wr_take) begin
      dat_q <= merge(dat_q, wd16, lanes(cur_tgt, T_DAT_LO, T_DAT_HI, T_DAT_W));
      dat2_q <= merge(dat2_q, wd16, lanes(cur_tgt, T_D2_LO, T_D2_HI, T_D2_W));
    end
  end

  // Data-full flag; a set in the same cycle beats a clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_full_flag_q <= 1'b0;
      dir_wr_q <= 1'b0;
    end else begin
      if (last_wr || (dma_ack && dma_st_q == D_READ)) begin
        data_full_flag_q <= 1'b1;
      end else if (last_rd || (dma_ack && dma_st_q == D_WRITE)) begin
        data_full_flag_q <= 1'b0; // [RQ14]
      end
      if (last_wr) dir_wr_q <= 1'b1;
      else if (last_rd) dir_wr_q <= 1'b0;
    end
  end

  // DMA engine: drains a full register, or prefetches into an empty one
  always_ff @(posedge mclk) begin
    if (rst) begin
      dma_st_q <= D_IDLE;
      dma_q <= '0;
    end else begin
      case (dma_st_q)
        D_IDLE: begin
          if (ctl_q[CTL_DMA_EN] && !last_wr && !last_rd) begin // [RQ12]
            if (data_full_flag_q && dir_wr_q) begin
              dma_st_q <= D_WRITE;
              dma_q <= '{1'b1, 1'b1, {ext_q, ptr_q},
                         {ctl_q[CTL_DMA_W] ? dat2_q : 16'h0000, dat_q}};
            end else if (!data_full_flag_q && !dir_wr_q) begin
              dma_st_q <= D_READ;
              dma_q <= '{1'b1, 1'b0, {ext_q, ptr_q}, 32'h00000000};
            end
          end
        end
        default: begin
          if (dma_ack) begin
            dma_st_q <= D_IDLE;
            dma_q.req <= 1'b0;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Host read data
  // ==========================================================================
  // Read data is captured at the leading edge and held for the access
  always_ff @(posedge mclk) begin
    if (rst) begin
      host_rdata_q <= 16'h0000;
      host_rdata_oe_q <= 1'b0;
    end else begin
      host_rdata_oe_q <= host.rd;
      if (rd_lead) begin
        case (cur_tgt)
          T_PTR_LO: host_rdata_q <= {8'h00, ptr_q[7:0]};
          T_PTR_HI: host_rdata_q <= {8'h00, ptr_q[15:8]};
          T_PTR_W: host_rdata_q <= ptr_q;
          T_DAT_LO: host_rdata_q <= {8'h00, dat_q[7:0]};
          T_DAT_HI: host_rdata_q <= {8'h00, dat_q[15:8]};
          T_DAT_W: host_rdata_q <= dat_q;
          T_MSK_LO: host_rdata_q <= {8'h00, msk_q[7:0] | EMR_RES_ONES[7:0]};
          T_MSK_HI: host_rdata_q <= {8'h00, msk_q[15:8] | EMR_RES_ONES[15:8]};
          T_MSK_W: host_rdata_q <= msk_q | EMR_RES_ONES;
          T_ESR: host_rdata_q <= {8'h00, esr_q};
          T_CTL_LO: host_rdata_q <= {8'h00, host_interrupt_flag_q,
                                     data_full_flag_q, ctl_q[4:0]};
          T_CTL_HI: host_rdata_q <= {8'h00, ctl_q[15:8]};
          T_CTL_W: host_rdata_q <= {ctl_q[15:7], host_interrupt_flag_q,
                                    data_full_flag_q, ctl_q[4:0]};
          T_IW_LO: host_rdata_q <= {8'h00, iw_q[7:0]};
          T_IW_HI: host_rdata_q <= {8'h00, iw_q[15:8]};
          T_IW_W: host_rdata_q <= iw_q;
          T_EXT: host_rdata_q <= {8'h00, ext_q};
          T_D2_LO: host_rdata_q <= {8'h00, dat2_q[7:0]};
          T_D2_HI: host_rdata_q <= {8'h00, dat2_q[15:8]};
          T_D2_W: host_rdata_q <= dat2_q;
          default: host_rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_reset_ctl_value: assert property ($past(rst) |-> // [RQ17]
    ctl_q == CTL_RESET && msk_q == EMR_RESET)
    else $error("control or mask wrong after reset");
  a_wide_bit_write: assert property (wr_take && cur_tgt == T_CTL_W |=> // [RQ4]
    ctl_q[CTL_WIDE] == $past(host.wdata[CTL_WIDE]))
    else $error("wide select not written");
  a_legacy_iw_map: assert property (!ctl_q[CTL_MAP] && host.sel >= SEL_IW_LO
    |-> cur_tgt == T_IW_HI) // [RQ6]
    else $error("legacy high codes must hit interrupt high");
  a_ext_ctl_high: assert property (ctl_q[CTL_MAP] && host.sel == SEL_CTL_HI
    |-> cur_tgt == T_CTL_HI) // [RQ9]
    else $error("code 1010 must reach control high");
  a_wide_odd_none: assert property (ctl_q[CTL_MAP] && ctl_q[CTL_WIDE]
    && host.sel == SEL_PTR_HI |-> cur_tgt == T_NONE) // [RQ8]
    else $error("odd code not reserved in 16-bit mode");
  a_esr_read_only: assert property (wr_take && cur_tgt == T_ESR && !rd_trail
    |=> esr_q == ($past(esr_q) | ($past(err_set) & ESR_VALID))) // [RQ2]
    else $error("host write changed error source");
  a_iflag_gated: assert property (!ctl_q[CTL_IFE] |=> // [RQ11]
    host_interrupt_flag_q == $past(host_interrupt_flag_q))
    else $error("interrupt flag moved while disabled");
  a_dma_disabled: assert property (!ctl_q[CTL_DMA_EN] && dma_st_q == D_IDLE
    |=> !dma_q.req) // [RQ12]
    else $error("DMA request while disabled");
  a_dma_wide_fill: assert property (dma_ack && dma_st_q == D_READ
    && ctl_q[CTL_DMA_W] |=> dat2_q == $past(dma_rdata[31:16])) // [RQ13]
    else $error("32-bit DMA did not fill second data");
  a_lead_edge_clr: assert property (!ctl_q[CTL_FLG] && last_rd && !last_wr
    && !(dma_ack && dma_st_q == D_READ) |=> !data_full_flag_q) // [RQ14]
    else $error("leading-edge read did not clear data full");
  a_restart_pulse: assert property ($rose(ctl_q[CTL_RUN]) |=> // [RQ15]
    core_restart_q ##1 !core_restart_q)
    else $error("restart pulse missing or too long");
  a_auto_incr: assert property (dma_ack && dma_st_q != D_IDLE
    && ctl_q[CTL_AUTO] && !wr_take |=> {ext_q, ptr_q} == 24'($past({ext_q,
    ptr_q}) + ($past(ctl_q[CTL_DMA_W]) ? INC_32 : INC_16))) // [RQ16]
    else $error("pointer not incremented after DMA");

  c_wide_ctl_write: cover property (wr_take && cur_tgt == T_CTL_W);
  c_dma_write_done: cover property (dma_ack && dma_st_q == D_WRITE);
  c_trail_iw_clear: cover property (ctl_q[CTL_FLG] && iw_rd
    && host_interrupt_flag_q);

endmodule : host_parallel_port_regsel

// file: host_port_pkg.sv
// Constants, codes and carriers shared by the parallel host port logic
package host_port_pkg;

  // ==========================================================================
  // Register-select codes on the host bus
  // ==========================================================================
  localparam logic [3:0] SEL_PTR_LO = 4'h0;
  localparam logic [3:0] SEL_PTR_HI = 4'h1;
  localparam logic [3:0] SEL_DAT_LO = 4'h2;
  localparam logic [3:0] SEL_DAT_HI = 4'h3;
  localparam logic [3:0] SEL_MSK_LO = 4'h4;
  localparam logic [3:0] SEL_MSK_HI = 4'h5;
  localparam logic [3:0] SEL_ESR = 4'h6;
  localparam logic [3:0] SEL_CTL_LO = 4'h7; // Port control register offset
  localparam logic [3:0] SEL_IW_LO = 4'h8;
  localparam logic [3:0] SEL_IW_HI = 4'h9;
  localparam logic [3:0] SEL_CTL_HI = 4'hA;
  localparam logic [3:0] SEL_EXT = 4'hB;
  localparam logic [3:0] SEL_D2_LO = 4'hC;
  localparam logic [3:0] SEL_D2_HI = 4'hD;

  // ==========================================================================
  // Port control fields and reset values
  // ==========================================================================
  localparam int CTL_RUN = 0;
  localparam int CTL_MAP = 1;
  localparam int CTL_IFE = 2;
  localparam int CTL_DMA_EN = 3;
  localparam int CTL_AUTO = 4;
  localparam int CTL_DF_STAT = 5;
  localparam int CTL_IF_STAT = 6;
  localparam int CTL_DMA_W = 8;
  localparam int CTL_WIDE = 9;
  localparam int CTL_FLG = 10;
  localparam logic [15:0] CTL_RESET = 16'h0001;
  localparam logic [15:0] CTL_WMASK = 16'h071F;
  localparam logic [15:0] EMR_RESET = 16'hFFFF;
  localparam logic [15:0] EMR_RES_ONES = 16'h0D0D;
  localparam logic [7:0] ESR_VALID = 8'hF6;
  localparam int ESR_WIW = 2;
  localparam logic [23:0] INC_16 = 24'h000002;
  localparam logic [23:0] INC_32 = 24'h000004;

  // ==========================================================================
  // Decoded access targets and carriers
  // ==========================================================================
  typedef enum logic [4:0] {
    T_NONE = 5'b00000, T_PTR_LO = 5'b00001, T_PTR_HI = 5'b00010,
    T_PTR_W = 5'b00011, T_DAT_LO = 5'b00100, T_DAT_HI = 5'b00101,
    T_DAT_W = 5'b00110, T_MSK_LO = 5'b00111, T_MSK_HI = 5'b01000,
    T_MSK_W = 5'b01001, T_ESR = 5'b01010, T_CTL_LO = 5'b01011,
    T_CTL_HI = 5'b01100, T_CTL_W = 5'b01101, T_IW_LO = 5'b01110,
    T_IW_HI = 5'b01111, T_IW_W = 5'b10000, T_EXT = 5'b10001,
    T_D2_LO = 5'b10010, T_D2_HI = 5'b10011, T_D2_W = 5'b10100
  } tgt_e;

  typedef enum logic [1:0] {
    D_IDLE = 2'b00, D_WRITE = 2'b01, D_READ = 2'b10
  } dma_st_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] sel;
    logic [15:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic req;
    logic wr;
    logic [23:0] addr;
    logic [31:0] wdata;
  } dma_req_s;

endpackage : host_port_pkg

// file: host_model.sv
// Host side model that drives parallel register accesses
`timescale 1ns/1ps
module host_model
  import host_port_pkg::*;
(
  input wire logic mclk,
  input wire logic [15:0] host_rdata_q,
  output host_port_pkg::host_req_s host
);
  // ==========================================================================
  // Idle bus state
  // ==========================================================================
  // Released lines show the inverse of their last value, never a stale match
  initial begin
    host = '0;
  end

  // Write strobe held two cycles, then a two-cycle idle gap
  task automatic wr(input logic [3:0] sel, input logic [15:0] data);
    @(posedge mclk);
    host.sel <= sel;
    host.wdata <= data;
    host.wr <= 1'b1;
    repeat (2) @(posedge mclk);
    host.wr <= 1'b0;
    @(posedge mclk);
    host.sel <= ~host.sel;
    host.wdata <= ~host.wdata;
    @(posedge mclk);
  endtask : wr

  // Read data taken one cycle after the leading edge, strobe held three
  task automatic rd(input logic [3:0] sel, output logic [15:0] data);
    @(posedge mclk);
    host.sel <= sel;
    host.rd <= 1'b1;
    repeat (2) @(posedge mclk);
    data = host_rdata_q;
    @(posedge mclk);
    host.rd <= 1'b0;
    @(posedge mclk);
    host.sel <= ~host.sel;
    host.wdata <= ~host.wdata;
    @(posedge mclk);
  endtask : rd
endmodule : host_model

// file: tb.sv
// Self-checking testbench for the parallel host port register logic
`timescale 1ns/1ps
module tb;
  import host_port_pkg::*;
  logic mclk;
  logic rst;
  host_req_s host;
  logic [15:0] host_rdata_q;
  logic host_rdata_oe_q;
  logic data_full_flag_q;
  logic host_interrupt_flag_q;
  logic core_iw_write;
  logic [15:0] core_iw_wdata;
  logic [15:0] iw_to_core_q;
  logic core_err_halt_q;
  logic [7:0] err_set;
  logic core_run_q;
  logic core_restart_q;
  dma_req_s dma_q;
  logic dma_ack = 1'b0;
  logic [31:0] dma_rdata = 32'h00000000;
  logic [2:0] dcnt = 3'd0;
  int dma_n = 0;
  int errors;
  int check_count;
  logic wlog_ok = 1'b0;
  logic [23:0] wlog_addr;
  logic [31:0] wlog_data;
  logic restart_seen = 1'b0;
  logic [15:0] r;

  host_parallel_port_regsel i_host_parallel_port_regsel (
    .mclk(mclk), .rst(rst), .host(host),
    .host_rdata_q(host_rdata_q), .host_rdata_oe_q(host_rdata_oe_q),
    .data_full_flag_q(data_full_flag_q),
    .host_interrupt_flag_q(host_interrupt_flag_q),
    .core_iw_write(core_iw_write), .core_iw_wdata(core_iw_wdata),
    .iw_to_core_q(iw_to_core_q), .iw_to_core_stb_q(), .err_set(err_set),
    .core_err_halt_q(core_err_halt_q), .core_run_q(core_run_q),
    .core_restart_q(core_restart_q), .dma_q(dma_q), .dma_ack(dma_ack),
    .dma_rdata(dma_rdata)
  );

  host_model i_host_model (
    .mclk(mclk), .host_rdata_q(host_rdata_q), .host(host)
  );

  // ==========================================================================
  // Clock, memory responder and monitors
  // ==========================================================================
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Slow memory: ack five cycles after the request, data only with the ack
  always @(posedge mclk) begin
    dma_ack <= 1'b0;
    dma_rdata <= ~dma_rdata;
    if (dma_q.req && dcnt < 3'd4) begin
      dcnt <= dcnt + 3'd1;
    end else if (dcnt == 3'd4) begin
      dma_ack <= 1'b1;
      dma_rdata <= 32'h0000C0DE;
      dma_n <= dma_n + 1;
      dcnt <= 3'd5;
      if (dma_q.wr) begin
        wlog_ok <= 1'b1;
        wlog_addr <= dma_q.addr;
        wlog_data <= dma_q.wdata;
      end
    end else if (dcnt == 3'd5) begin
      dcnt <= 3'd6;
    end else if (dcnt == 3'd6 && !dma_q.req) begin
      dcnt <= 3'd0;
    end
    if (core_restart_q === 1'b1) begin
      restart_seen <= 1'b1;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic pulse_iw();
    @(posedge mclk);
    core_iw_write <= 1'b1;
    @(posedge mclk);
    core_iw_write <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : pulse_iw

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // Watchdog sized well above the expected run of a few hundred cycles
  initial begin
    #400000;
    errors++;
    wrap_up();
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    rst <= 1'b1;
    core_iw_write <= 1'b0;
    core_iw_wdata <= 16'hA5C3;
    err_set <= 8'h00;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("run after reset", 32'h1, core_run_q);
    i_host_model.rd(4'h7, r);
    chk("ctl low reset", 32'h0001, r);
    // Legacy map: every high code reaches the interrupt word high byte
    i_host_model.wr(4'hB, 16'h005A);
    chk("iw to core", 32'h5A00, iw_to_core_q);
    i_host_model.rd(4'h9, r);
    chk("legacy 9", 32'h005A, r);
    i_host_model.rd(4'hE, r);
    chk("legacy E", 32'h005A, r);
    $display("test legacy done");
    // Map select first, or the control high byte stays out of reach
    i_host_model.wr(4'h7, 16'h0003);
    i_host_model.rd(4'hA, r);
    chk("ext ctl high", 32'h0000, r);
    i_host_model.wr(4'h0, 16'h0034);
    i_host_model.wr(4'h1, 16'h0012);
    i_host_model.wr(4'hB, 16'h0056);
    i_host_model.rd(4'hB, r);
    chk("ext ptr ext", 32'h0056, r);
    i_host_model.rd(4'hE, r);
    chk("ext reserved", 32'h0000, r);
    i_host_model.rd(4'h9, r);
    chk("ext iw high", 32'h005A, r);
    $display("test extended done");
    i_host_model.wr(4'hA, 16'h0002);
    i_host_model.rd(4'h7, r);
    chk("wide ctl", 32'h0203, r);
    i_host_model.rd(4'h0, r);
    chk("wide ptr", 32'h1234, r);
    i_host_model.rd(4'h1, r);
    chk("wide reserved", 32'h0000, r);
    i_host_model.rd(4'hB, r);
    chk("wide ptr ext", 32'h0056, r);
    $display("test wide done");
    // Bits 0 and 3 of the event input have no place in the error source
    @(posedge mclk);
    err_set <= 8'h0B;
    @(posedge mclk);
    err_set <= 8'h00;
    i_host_model.wr(4'h6, 16'hFFFF);
    i_host_model.rd(4'h6, r);
    chk("esr", 32'h0006, r);
    chk("halt masked", 32'h0, core_err_halt_q);
    i_host_model.rd(4'h6, r);
    chk("esr cleared", 32'h0000, r);
    $display("test esr done");
    i_host_model.wr(4'h7, 16'h021B);
    // Enabling with an empty register starts a prefetch; let it land first
    for (int i = 0; i < 60 && dma_n < 1; i++) begin
      @(posedge mclk);
    end
    repeat (2) @(posedge mclk);
    chk("prefetch done", 32'h1, dma_n);
    i_host_model.wr(4'h2, 16'hBEEF);
    for (int i = 0; i < 60 && !wlog_ok; i++) begin
      @(posedge mclk);
    end
    repeat (3) @(posedge mclk);
    chk("dma write seen", 32'h1, wlog_ok);
    chk("dma wdata", 32'h0000BEEF, wlog_data);
    chk("dma addr", 32'h561234 + 2 * (dma_n - 1), wlog_addr);
    chk("full after dma", 32'h0, data_full_flag_q);
    i_host_model.rd(4'h0, r);
    chk("ptr autoinc", 32'h1234 + 2 * dma_n, r);
    $display("test dma done");
    i_host_model.wr(4'h7, 16'h021F);
    pulse_iw();
    chk("iflag set", 32'h1, host_interrupt_flag_q);
    i_host_model.rd(4'h8, r);
    chk("iflag cleared", 32'h0, host_interrupt_flag_q);
    // Trailing-edge flag mode
    i_host_model.wr(4'h7, 16'h061F);
    pulse_iw();
    chk("iflag set trail", 32'h1, host_interrupt_flag_q);
    i_host_model.rd(4'h8, r);
    chk("iflag trail clr", 32'h0, host_interrupt_flag_q);
    i_host_model.wr(4'h7, 16'h021B);
    pulse_iw();
    chk("iflag gated", 32'h0, host_interrupt_flag_q);
    $display("test iflag done");
    i_host_model.wr(4'h7, 16'h021A);
    chk("halted", 32'h0, core_run_q);
    chk("no restart", 32'h0, restart_seen);
    i_host_model.wr(4'h7, 16'h021B);
    chk("running", 32'h1, core_run_q);
    chk("restart", 32'h1, restart_seen);
    $display("test run done");
    wrap_up();
  end
endmodule : tb
